// >>> src/rav_pkg.sv
package rav_pkg;

  // register byte offsets
  localparam logic [7:0] PERI_BUCK_ALT_SETTING_ADDR    = 8'hB9;
  localparam logic [7:0] LINREG_ONE_ALT_SETTING_ADDR   = 8'hBA;
  localparam logic [7:0] LINREG_TWO_ALT_SETTING_ADDR   = 8'hBB;
  localparam logic [7:0] LINREG_THREE_ALT_SETTING_ADDR = 8'hBC;

  // reset values (none documented, zero chosen)
  localparam logic [7:0] PERI_BUCK_ALT_RESET    = 8'h00;
  localparam logic [7:0] LINREG_ONE_ALT_RESET   = 8'h00;
  localparam logic [7:0] LINREG_TWO_ALT_RESET   = 8'h00;
  localparam logic [7:0] LINREG_THREE_ALT_RESET = 8'h00;

  // field positions
  localparam int SLEEP_BIT    = 7;
  localparam int RESERVED_BIT = 6;
  localparam int WIDE_CODE_W   = 7;
  localparam int NARROW_CODE_W = 6;

  // voltage coding in millivolts
  localparam int STEP_MV           = 20;
  localparam int PERI_BUCK_BASE_MV = 800;
  localparam int LINREG_ONE_BASE_MV   = 600;
  localparam int LINREG_TWO_BASE_MV   = 600;
  localparam int LINREG_THREE_BASE_MV = 900;
  localparam int LINREG_ONE_MAX_MV    = 1200;
  localparam int LINREG_TWO_MAX_MV    = 1800;
  localparam logic [5:0] LINREG_ONE_CLAMP_CODE = 6'h1E;
  localparam logic [5:0] LINREG_TWO_CLAMP_CODE = 6'h3C;

  // mode of one regulator as seen by its power stage
  typedef struct packed {
    logic        sleep;
    logic [11:0] target_mv;
  } rav_rail_t;

endpackage

// >>> src/rav_regs.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
// Summary of operation
// - with alternate setting active and buck bit 7 set, the peripheral buck sleeps.
// - with buck bit 7 clear, the peripheral buck runs in synchronous mode.
// - buck voltage is bits 6:0, 0.80 V at code zero plus 20 mV a step, 3.34 V at the top.
// - bit 7 of each linear regulator register selects sleep when set, normal when clear.
// - first linear regulator voltage is bits 5:0, 0.60 V plus 20 mV a step.
// - first linear regulator codes 011110 and 011111 both give 1.20 V.
// - second linear regulator voltage is bits 5:0, 0.60 V plus 20 mV a step.
// - second linear regulator codes 111100 and above give 1.80 V.
// - third linear regulator voltage is bits 6:0, 0.90 V plus 20 mV a step, up to 3.44 V.
// - bit 6 of the first and second linear regulator registers is reserved read/write.
module rav_regs (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [3:0]        alt_select,
  output rav_pkg::rav_rail_t     peripheral_buck,
  output rav_pkg::rav_rail_t     linreg_one,
  output rav_pkg::rav_rail_t     linreg_two,
  output rav_pkg::rav_rail_t     linreg_three
);

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] peri_buck_alt_setting;
  logic [7:0] linreg_one_alt_setting;
  logic [7:0] linreg_two_alt_setting;
  logic [7:0] linreg_three_alt_setting;

  // one slot per register; bit 6 of linreg one and two is kept though it drives nothing
  rav_alt_slot #(
    .ADDR      (rav_pkg::PERI_BUCK_ALT_SETTING_ADDR),
    .RESET_VAL (rav_pkg::PERI_BUCK_ALT_RESET)
  ) i_peri_slot (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .value     (peri_buck_alt_setting)
  );

  rav_alt_slot #(
    .ADDR      (rav_pkg::LINREG_ONE_ALT_SETTING_ADDR),
    .RESET_VAL (rav_pkg::LINREG_ONE_ALT_RESET)
  ) i_one_slot (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .value     (linreg_one_alt_setting)
  );

  rav_alt_slot #(
    .ADDR      (rav_pkg::LINREG_TWO_ALT_SETTING_ADDR),
    .RESET_VAL (rav_pkg::LINREG_TWO_ALT_RESET)
  ) i_two_slot (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .value     (linreg_two_alt_setting)
  );

  rav_alt_slot #(
    .ADDR      (rav_pkg::LINREG_THREE_ALT_SETTING_ADDR),
    .RESET_VAL (rav_pkg::LINREG_THREE_ALT_RESET)
  ) i_three_slot (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .value     (linreg_three_alt_setting)
  );

  //////////////////////////////////////////////////////////////////////////////
  // registered read path; never stalls the master
  rav_read_port i_read_port (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .reg_addr    (reg_addr),
    .reg_rd      (reg_rd),
    .peri_value  (peri_buck_alt_setting),
    .one_value   (linreg_one_alt_setting),
    .two_value   (linreg_two_alt_setting),
    .three_value (linreg_three_alt_setting),
    .reg_rdata   (reg_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decoded targets; 12 bits hold up to 4095 mV
  logic [11:0] next_peri_mv;
  logic [11:0] next_one_mv;
  logic [11:0] next_two_mv;
  logic [11:0] next_three_mv;

  rav_rail_decode #(
    .CODE_W     (rav_pkg::WIDE_CODE_W),
    .BASE_MV    (rav_pkg::PERI_BUCK_BASE_MV),
    .CLAMP_EN   (1'h0),
    .CLAMP_CODE (0),
    .MAX_MV     (0)
  ) i_peri_decode (
    .setting    (peri_buck_alt_setting),
    .target_mv  (next_peri_mv)
  );

  rav_rail_decode #(
    .CODE_W     (rav_pkg::NARROW_CODE_W),
    .BASE_MV    (rav_pkg::LINREG_ONE_BASE_MV),
    .CLAMP_EN   (1'h1),
    .CLAMP_CODE (rav_pkg::LINREG_ONE_CLAMP_CODE),
    .MAX_MV     (rav_pkg::LINREG_ONE_MAX_MV)
  ) i_one_decode (
    .setting    (linreg_one_alt_setting),
    .target_mv  (next_one_mv)
  );

  rav_rail_decode #(
    .CODE_W     (rav_pkg::NARROW_CODE_W),
    .BASE_MV    (rav_pkg::LINREG_TWO_BASE_MV),
    .CLAMP_EN   (1'h1),
    .CLAMP_CODE (rav_pkg::LINREG_TWO_CLAMP_CODE),
    .MAX_MV     (rav_pkg::LINREG_TWO_MAX_MV)
  ) i_two_decode (
    .setting    (linreg_two_alt_setting),
    .target_mv  (next_two_mv)
  );

  rav_rail_decode #(
    .CODE_W     (rav_pkg::WIDE_CODE_W),
    .BASE_MV    (rav_pkg::LINREG_THREE_BASE_MV),
    .CLAMP_EN   (1'h0),
    .CLAMP_CODE (0),
    .MAX_MV     (0)
  ) i_three_decode (
    .setting    (linreg_three_alt_setting),
    .target_mv  (next_three_mv)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sleep bits share one position in all four registers
  logic peri_sleep_bit;
  logic one_sleep_bit;
  logic two_sleep_bit;
  logic three_sleep_bit;

  assign peri_sleep_bit  = peri_buck_alt_setting[rav_pkg::SLEEP_BIT];
  assign one_sleep_bit   = linreg_one_alt_setting[rav_pkg::SLEEP_BIT];
  assign two_sleep_bit   = linreg_two_alt_setting[rav_pkg::SLEEP_BIT];
  assign three_sleep_bit = linreg_three_alt_setting[rav_pkg::SLEEP_BIT];

  // rails not on their alternate set show all zero: this bank does not drive them
  rav_rail_drive i_peri_drive (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .alt_active (alt_select[0]),
    .sleep_bit  (peri_sleep_bit),
    .next_mv    (next_peri_mv),
    .rail       (peripheral_buck)
  );

  rav_rail_drive i_one_drive (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .alt_active (alt_select[1]),
    .sleep_bit  (one_sleep_bit),
    .next_mv    (next_one_mv),
    .rail       (linreg_one)
  );

  rav_rail_drive i_two_drive (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .alt_active (alt_select[2]),
    .sleep_bit  (two_sleep_bit),
    .next_mv    (next_two_mv),
    .rail       (linreg_two)
  );

  rav_rail_drive i_three_drive (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .alt_active (alt_select[3]),
    .sleep_bit  (three_sleep_bit),
    .next_mv    (next_three_mv),
    .rail       (linreg_three)
  );

endmodule

//////////////////////////////////////////////////////////////////////////////
// one byte-wide register; full byte kept so reads mirror writes
module rav_alt_slot #(
  parameter logic [7:0] ADDR      = 8'h00,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] value
);

  logic hit;

  // exact decode: neighbouring offsets belong to other banks
  assign hit = reg_wr && (reg_addr == ADDR);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      value <= RESET_VAL;
    end else if (hit) begin
      value <= reg_wdata;
    end
  end

endmodule

//////////////////////////////////////////////////////////////////////////////
// code to millivolts; optional ceiling for rails whose top codes saturate
module rav_rail_decode #(
  parameter int CODE_W     = 6,
  parameter int BASE_MV    = 600,
  parameter bit CLAMP_EN   = 1'h0,
  parameter int CLAMP_CODE = 0,
  parameter int MAX_MV     = 0
) (
  input  wire logic [7:0]  setting,
  output logic      [11:0] target_mv
);

  logic [CODE_W-1:0] code;
  logic              clamped;
  logic [11:0]       linear_mv;

  assign code = setting[CODE_W-1:0];

  // codes at or past the clamp point all map to the same ceiling
  assign clamped = CLAMP_EN && (int'(code) >= CLAMP_CODE);

  assign linear_mv = 12'(BASE_MV + rav_pkg::STEP_MV * int'(code));

  always_comb begin
    if (clamped) begin
      target_mv = 12'(MAX_MV);
    end else begin
      target_mv = linear_mv;
    end
  end

endmodule

//////////////////////////////////////////////////////////////////////////////
// read data stands one cycle after the strobe, zero otherwise
module rav_read_port (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] peri_value,
  input  wire logic [7:0] one_value,
  input  wire logic [7:0] two_value,
  input  wire logic [7:0] three_value,
  output logic      [7:0] reg_rdata
);

  logic [7:0] next_rdata;

  // unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        rav_pkg::PERI_BUCK_ALT_SETTING_ADDR:    next_rdata = peri_value;
        rav_pkg::LINREG_ONE_ALT_SETTING_ADDR:   next_rdata = one_value;
        rav_pkg::LINREG_TWO_ALT_SETTING_ADDR:   next_rdata = two_value;
        rav_pkg::LINREG_THREE_ALT_SETTING_ADDR: next_rdata = three_value;
        default:                                next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

//////////////////////////////////////////////////////////////////////////////
// registered rail output; sleep and target kept as separate flops
module rav_rail_drive (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          alt_active,
  input  wire logic          sleep_bit,
  input  wire logic [11:0]   next_mv,
  output rav_pkg::rav_rail_t rail
);

  logic        next_sleep;
  logic [11:0] next_target;
  logic        sleep_q;
  logic [11:0] target_q;

  // off the alternate set the rail reads as sleep low, target zero
  always_comb begin
    next_sleep  = 1'h0;
    next_target = 12'h000;
    if (alt_active) begin
      next_sleep  = sleep_bit;
      next_target = next_mv;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sleep_q <= 1'h0;
    end else begin
      sleep_q <= next_sleep;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      target_q <= 12'h000;
    end else begin
      target_q <= next_target;
    end
  end

  assign rail = {sleep_q, target_q};

endmodule

// >>> testbench/rav_properties.sv
`timescale 1ns/1ns
module rav_properties (
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic [3:0]         alt_select,
  input wire rav_pkg::rav_rail_t peripheral_buck,
  input wire rav_pkg::rav_rail_t linreg_one,
  input wire rav_pkg::rav_rail_t linreg_two,
  input wire rav_pkg::rav_rail_t linreg_three
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata busy");
  a_unmapped_read: assert property (reg_rd && !(reg_addr inside {[8'hB9:8'hBC]}) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_write_readback: assert property (reg_wr && reg_addr inside {[8'hB9:8'hBC]} ##1 reg_rd &&
    reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
  a_rail_off: assert property (($past(alt_select[0]) || peripheral_buck == 13'h0) &&
    ($past(alt_select[1]) || linreg_one == 13'h0) && ($past(alt_select[2]) || linreg_two == 13'h0)
    && ($past(alt_select[3]) || linreg_three == 13'h0)) else $error("rail active off alt");
  a_buck_follow: assert property (reg_wr && reg_addr == 8'hB9 && alt_select[0] ##1 alt_select[0]
    |=> peripheral_buck == {$past(reg_wdata[7], 2), 12'(800 + 20 * $past(reg_wdata[6:0], 2))})
    else $error("buck rail");
  a_one_range: assert property ($past(alt_select[1]) |-> linreg_one.target_mv inside
    {[600:1200]} && linreg_one.target_mv % 20 == 0) else $error("linreg one range");
  a_two_range: assert property ($past(alt_select[2]) |-> linreg_two.target_mv inside
    {[600:1800]} && linreg_two.target_mv % 20 == 0) else $error("linreg two range");
  a_three_range: assert property ($past(alt_select[3]) |-> linreg_three.target_mv inside
    {[900:3440]} && linreg_three.target_mv % 20 == 0) else $error("linreg three range");
endmodule
bind rav_regs rav_properties i_rav_properties (.*);

// >>> testbench/regulator_alt_voltage_regs_test.sv
`timescale 1ns/1ns
module regulator_alt_voltage_regs_test;
  logic               clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0]         reg_addr = 0, reg_wdata = 0, reg_rdata, q [$], d;
  logic [3:0]         alt_select = 0;
  logic [7:0]         regv [4] = '{default: 8'h00};
  rav_pkg::rav_rail_t rail [4];
  int                 errors = 0, n_compared = 0;
  rav_regs i_rav_regs (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alt_select(alt_select),
    .peripheral_buck(rail[0]), .linreg_one(rail[1]), .linreg_two(rail[2]), .linreg_three(rail[3]));
  initial forever #20 clock = ~clock;
  task automatic print_verdict;
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bench-side decode, saturating where the upper codes clamp
  function automatic logic [12:0] dec(input int k, input logic [7:0] v);
    int mv;
    mv = (k == 0) ? 800 + 20 * v[6:0] : (k == 3) ? 900 + 20 * v[6:0] : 600 + 20 * v[5:0];
    if (k == 1 && mv > 1200) mv = 1200;
    if (k == 2 && mv > 1800) mv = 1800;
    return {v[7], 12'(mv)};
  endfunction
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dt);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= dt;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, q.pop_front());
  end
  initial begin
    void'($urandom(32'h31F9A619));
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    for (int k = 0; k < 4; k++) begin q.push_back(8'h00); acc(0, 1, 8'(8'hB9 + k), 0); end
    for (int n = 0; n < 30; n++) begin
      for (int k = 0; k < 4; k++) begin
        d = n == 0 ? 8'hFF : n == 1 ? 8'hDE : n == 2 ? 8'h7C : 8'($urandom);
        acc(1, 0, 8'(8'hB9 + k), d);
        regv[k] = d;
        q.push_back(d);
        acc(0, 1, 8'(8'hB9 + k), 0);
      end
      acc(1, 0, 8'hB8, 8'h55);
      q.push_back(8'h00);
      acc(0, 1, 8'hB8, 0);
      acc(0, 0, 8'hBD, 0);
      alt_select <= (n < 3) ? 4'hF : 4'($urandom);
      @(posedge clock);
      @(negedge clock);
      for (int k = 0; k < 4; k++) begin
        chk(rail[k], alt_select[k] ? dec(k, regv[k]) : 13'h0000);
      end
    end
    print_verdict;
  end
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule
